/* File: logic/srw_top.sv */
/*
 * Stop-mode recovery control and retriggerable watchdog.
 * Assumes the CPU reports its Stop and Halt states and watchdog instruction
 * as synchronous levels/pulses, and the RC oscillator arrives as a
 * synchronous level that toggles slower than CLK.
 */
// Functional notes
// - Bits 4:2 pick wake source: reset only, reserved, port3 pins 1-3, port2 pin 7.
// - Code 110 wakes on NOR of port2 pins 0-3; 111 on NOR of 0-7.
// - Port2 pins set as outputs read as inactive to the NOR terms.
// - Bit 5 low skips the power-on delay after wake; resets to 1.
// - Bit 6 picks high-level wake when 1, low-level when 0; resets 0.
// - Bit 7 reads 1 after Stop recovery, 0 after any other reset.
// - Watchdog is a retriggerable one-shot that resets the CPU at terminal count.
// - Watchdog idles until first watchdog instruction; each later one restarts it.
// - Watchdog counter advances on the RC oscillator, not the CPU clock.
// - The watchdog instruction also updates zero, sign and overflow flags.
// - Mode bits 1:0 pick timeout tap, bit 2 Halt enable, bit 3 Stop enable.
// - Mode register writable only 120 clocks after reset, then locked.
// - Mode register is write-only; reads never return its contents.
`timescale 1ns/1ps
module srw_top #(
    parameter int               CNT_W   = 16,
    parameter logic [CNT_W-1:0] TAP0    = CNT_W'(16'h0100),
    parameter logic [CNT_W-1:0] TAP1    = CNT_W'(16'h0200),
    parameter logic [CNT_W-1:0] TAP2    = CNT_W'(16'h0400),
    parameter logic [CNT_W-1:0] TAP3    = CNT_W'(16'h1000),
    parameter logic [1:0]       DEF_TAP = 2'h0
) (
    // Clock and reset
    input  wire logic               CLK,
    input  wire logic               RST,
    // Register port
    input  wire logic [7:0]         ADDR,
    input  wire logic [7:0]         WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic [7:0]              RDATA,
    // CPU side
    input  wire logic               CPU_STOP,
    input  wire logic               CPU_HALT,
    input  wire logic               WDT_EXEC,
    output logic                    WAKE,
    output logic                    WAKE_DELAY_EN,
    output logic                    WDT_RESET,
    output logic                    FLAG_WE,
    output srw_pkg::srw_flags_s     FLAGS,
    output logic                    IRQ,
    // Wake pins and RC oscillator
    input  wire logic [7:0]         PORT2_IN,
    input  wire logic [7:0]         PORT2_IS_OUT,
    input  wire logic [3:1]         PORT3_IN,
    input  wire logic               RC_OSC
);

    logic [2:0]              src_code;
    logic                    dly_sel;
    logic                    lvl_sel;
    logic                    warm;
    srw_pkg::srw_wdmode_s    wd_mode;
    srw_pkg::srw_wd_e        wd_state;
    logic [CNT_W-1:0]        wd_cnt;
    logic [CNT_W-1:0]        wd_period;
    logic [srw_pkg::WIN_W-1:0] win_cnt;
    logic [srw_pkg::IRQ_W-1:0] irq_stat;
    logic [srw_pkg::IRQ_W-1:0] irq_mask;
    logic [srw_pkg::IRQ_W-1:0] irq_set;
    logic [7:0]              p2_live;
    logic                    nor_low4;
    logic                    nor_all8;
    logic                    src_val;
    logic                    src_valid;
    logic                    wake_hit;
    logic                    woken;
    logic                    rc_q;
    logic                    rc_rise;
    logic                    wd_active;
    logic                    wd_timeout;
    logic                    win_open;
    logic                    wr_wdm;
    logic                    rd_stat;
    logic [7:0]              next_rdata;

    // Output-configured pins look inactive so they never hold the NOR low
    assign p2_live  = PORT2_IN & ~PORT2_IS_OUT;
    assign nor_low4 = ~|p2_live[3:0];
    assign nor_all8 = ~|p2_live;

    always_comb begin
        src_val   = 1'b0;
        src_valid = 1'b1;
        case (src_code)
            srw_pkg::SRC_PORT3_PIN1: src_val = PORT3_IN[1];
            srw_pkg::SRC_PORT3_PIN2: src_val = PORT3_IN[2];
            srw_pkg::SRC_PORT3_PIN3: src_val = PORT3_IN[3];
            srw_pkg::SRC_PORT2_PIN7: src_val = p2_live[7];
            srw_pkg::SRC_NOR_LOW4:   src_val = nor_low4;
            srw_pkg::SRC_NOR_ALL8:   src_val = nor_all8;
            default:                 src_valid = 1'b0;
        endcase
    end

    // Level-sensitive: the active level chosen by lvl_sel wakes the part
    assign wake_hit = CPU_STOP && !woken && src_valid && (src_val == lvl_sel);

    // One wake pulse per Stop; re-armed when the CPU leaves Stop
    always_ff @(posedge CLK) begin
        if (RST) begin
            WAKE  <= 1'b0;
            woken <= 1'b0;
        end else begin
            WAKE <= wake_hit;
            if (!CPU_STOP) begin
                woken <= 1'b0;
            end else if (wake_hit) begin
                woken <= 1'b1;
            end
        end
    end

    assign WAKE_DELAY_EN = dly_sel;

    assign win_open = (win_cnt != '0);
    assign wr_wdm   = WR && (ADDR == srw_pkg::ADDR_WDMODE);
    assign rd_stat  = RD && (ADDR == srw_pkg::ADDR_IRQ_STAT);

    // Recovery control register; warm flag tracks the kind of last reset
    always_ff @(posedge CLK) begin
        if (RST) begin
            src_code <= srw_pkg::SRC_RST;
            dly_sel  <= srw_pkg::DLY_RST;
            lvl_sel  <= srw_pkg::LVL_RST;
            warm     <= 1'b0;
        end else begin
            if (WR && (ADDR == srw_pkg::ADDR_RECOVERY)) begin
                src_code <= WDATA[srw_pkg::SRC_LSB +: 3];
                dly_sel  <= WDATA[srw_pkg::DLY_BIT];
                lvl_sel  <= WDATA[srw_pkg::LVL_BIT];
            end
            if (WAKE) begin
                warm <= 1'b1;
            end else if (WDT_RESET) begin
                warm <= 1'b0;
            end
        end
    end

    // Lock window reopens on every reset the block causes or sees
    always_ff @(posedge CLK) begin
        if (RST) begin
            win_cnt <= srw_pkg::WIN_OSC_CLOCKS;
        end else if (WAKE || WDT_RESET) begin
            win_cnt <= srw_pkg::WIN_OSC_CLOCKS;
        end else if (win_open) begin
            win_cnt <= win_cnt - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wd_mode <= '{stop_en: srw_pkg::STOP_RST, halt_en: srw_pkg::HALT_RST,
                         tap: DEF_TAP};
        end else if (wr_wdm && win_open) begin
            wd_mode.tap     <= WDATA[srw_pkg::TAP_LSB +: 2];
            wd_mode.halt_en <= WDATA[srw_pkg::HALT_BIT];
            wd_mode.stop_en <= WDATA[srw_pkg::STOP_BIT];
        end
    end

    always_comb begin
        case (wd_mode.tap)
            2'h0:    wd_period = TAP0;
            2'h1:    wd_period = TAP1;
            2'h2:    wd_period = TAP2;
            default: wd_period = TAP3;
        endcase
    end

    // RC input is sampled once; its rising edge is the counter's tick
    always_ff @(posedge CLK) begin
        if (RST) begin
            rc_q <= 1'b0;
        end else begin
            rc_q <= RC_OSC;
        end
    end

    assign rc_rise   = RC_OSC && !rc_q;
    assign wd_active = (wd_state == srw_pkg::WD_RUN) &&
                       !(CPU_HALT && !wd_mode.halt_en) &&
                       !(CPU_STOP && !wd_mode.stop_en);
    assign wd_timeout = wd_active && rc_rise && (wd_cnt >= wd_period - 1'b1);

    // Refresh takes priority over a timeout landing in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            wd_state <= srw_pkg::WD_IDLE;
            wd_cnt   <= '0;
        end else begin
            case (wd_state)
                srw_pkg::WD_IDLE: begin
                    if (WDT_EXEC) begin
                        wd_state <= srw_pkg::WD_RUN;
                        wd_cnt   <= '0;
                    end
                end
                srw_pkg::WD_RUN: begin
                    if (WDT_EXEC) begin
                        wd_cnt <= '0;
                    end else if (wd_timeout) begin
                        wd_state <= srw_pkg::WD_IDLE;
                        wd_cnt   <= '0;
                    end else if (wd_active && rc_rise) begin
                        wd_cnt <= wd_cnt + 1'b1;
                    end
                end
                default: wd_state <= srw_pkg::WD_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            WDT_RESET <= 1'b0;
        end else begin
            WDT_RESET <= wd_timeout && !WDT_EXEC;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            FLAG_WE <= 1'b0;
            FLAGS   <= '0;
        end else begin
            FLAG_WE <= WDT_EXEC;
            if (WDT_EXEC) begin
                FLAGS <= srw_pkg::WDT_FLAGS_VAL;
            end
        end
    end

    // Sticky status; a new event beats the read that clears it
    always_comb begin
        irq_set                      = '0;
        irq_set[srw_pkg::IRQ_WAKE]   = WAKE;
        irq_set[srw_pkg::IRQ_WDT]    = WDT_RESET;
        irq_set[srw_pkg::IRQ_LOCKED] = wr_wdm && !win_open;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= (rd_stat ? '0 : irq_stat) | irq_set;
            if (WR && (ADDR == srw_pkg::ADDR_IRQ_MASK)) begin
                irq_mask <= WDATA[srw_pkg::IRQ_W-1:0];
            end
        end
    end

    assign IRQ = |(irq_stat & irq_mask);

    always_comb begin
        next_rdata = 8'h00;
        if (ADDR == srw_pkg::ADDR_RECOVERY) begin
            next_rdata[srw_pkg::SRC_LSB +: 3] = src_code;
            next_rdata[srw_pkg::DLY_BIT]      = dly_sel;
            next_rdata[srw_pkg::LVL_BIT]      = lvl_sel;
            next_rdata[srw_pkg::WARM_BIT]     = warm;
        end else if (ADDR == srw_pkg::ADDR_IRQ_STAT) begin
            next_rdata[srw_pkg::IRQ_W-1:0] = irq_stat;
        end else if (ADDR == srw_pkg::ADDR_IRQ_MASK) begin
            next_rdata[srw_pkg::IRQ_W-1:0] = irq_mask;
        end
        // Mode register and unmapped offsets read as zero
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    wake_cause_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(WAKE) |-> $past(CPU_STOP && src_code != srw_pkg::SRC_RESET_ONLY
                              && src_code != srw_pkg::SRC_RESERVED))
        else $error("wake without a valid source in Stop");

    nor_mask_a: assert property (@(posedge CLK) disable iff (RST)
        (PORT2_IS_OUT == 8'hff) |-> (nor_all8 && nor_low4))
        else $error("output pin disturbed the NOR term");

    nor_low_a: assert property (@(posedge CLK) disable iff (RST)
        (CPU_STOP && !woken && src_code == srw_pkg::SRC_NOR_LOW4
         && lvl_sel && nor_low4) |=> WAKE)
        else $error("NOR of low port2 pins did not wake");

    reset_vals_a: assert property (@(posedge CLK)
        $past(RST) && !RST |-> (!lvl_sel && dly_sel && !warm))
        else $error("recovery fields wrong after reset");

    warm_flag_a: assert property (@(posedge CLK) disable iff (RST)
        WAKE |=> (warm ##1 warm || WDT_RESET))
        else $error("warm flag not set by recovery");

    wdt_idle_a: assert property (@(posedge CLK) disable iff (RST)
        (wd_state == srw_pkg::WD_IDLE && !WDT_EXEC) |=> !WDT_RESET)
        else $error("idle watchdog fired");

    wdt_refresh_a: assert property (@(posedge CLK) disable iff (RST)
        WDT_EXEC |=> (wd_cnt == '0 && wd_state == srw_pkg::WD_RUN))
        else $error("watchdog instruction did not restart count");

    wdt_oneshot_a: assert property (@(posedge CLK) disable iff (RST)
        WDT_RESET |-> (wd_state == srw_pkg::WD_IDLE && $past(wd_cnt) == wd_period - 1'b1))
        else $error("watchdog reset not at terminal count");

    rc_tick_a: assert property (@(posedge CLK) disable iff (RST)
        (wd_cnt != $past(wd_cnt) && wd_cnt != '0) |-> $past(rc_rise))
        else $error("watchdog counted without RC edge");

    flag_upd_a: assert property (@(posedge CLK) disable iff (RST)
        WDT_EXEC |=> (FLAG_WE && FLAGS == srw_pkg::WDT_FLAGS_VAL))
        else $error("condition flags not updated");

    mode_lock_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_wdm && !win_open) |=> $stable(wd_mode))
        else $error("locked mode register changed");

    mode_read_a: assert property (@(posedge CLK) disable iff (RST)
        (RD && ADDR == srw_pkg::ADDR_WDMODE) |=> (RDATA == 8'h00))
        else $error("mode register contents readable");

endmodule : srw_top

/* File: logic/srw_pkg.sv */
/*
 * Shared constants and carriers for the stop-recovery and watchdog block:
 * register offsets, field positions, reset values, recovery source codes
 * and the lock-window length.
 * Assumes an 8-bit register port and a single clock domain.
 */
package srw_pkg;

    // Register offsets (watchdog_mode fixed, the rest local)
    localparam logic [7:0] ADDR_RECOVERY = 8'h0b;
    localparam logic [7:0] ADDR_WDMODE   = 8'h0f;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h11;

    // stop_recovery_control field positions
    localparam int SRC_LSB   = 2;
    localparam int DLY_BIT   = 5;
    localparam int LVL_BIT   = 6;
    localparam int WARM_BIT  = 7;

    // watchdog_mode field positions
    localparam int TAP_LSB   = 0;
    localparam int HALT_BIT  = 2;
    localparam int STOP_BIT  = 3;

    // Recovery source codes
    localparam logic [2:0] SRC_RESET_ONLY   = 3'h0;
    localparam logic [2:0] SRC_RESERVED     = 3'h1;
    localparam logic [2:0] SRC_PORT3_PIN1   = 3'h2;
    localparam logic [2:0] SRC_PORT3_PIN2   = 3'h3;
    localparam logic [2:0] SRC_PORT3_PIN3   = 3'h4;
    localparam logic [2:0] SRC_PORT2_PIN7   = 3'h5;
    localparam logic [2:0] SRC_NOR_LOW4     = 3'h6;
    localparam logic [2:0] SRC_NOR_ALL8     = 3'h7;

    // Reset values
    localparam logic [2:0] SRC_RST  = 3'h0;
    localparam logic       DLY_RST  = 1'b1;
    localparam logic       LVL_RST  = 1'b0;
    localparam logic       HALT_RST = 1'b1;
    localparam logic       STOP_RST = 1'b0;

    // Write window on watchdog_mode, in oscillator clocks (60 processor cycles)
    localparam int         WIN_W          = 7;
    localparam logic [6:0] WIN_OSC_CLOCKS = 7'h78;

    // Interrupt status bits
    localparam int IRQ_W      = 3;
    localparam int IRQ_WAKE   = 0;
    localparam int IRQ_WDT    = 1;
    localparam int IRQ_LOCKED = 2;

    typedef struct packed {
        logic zero;
        logic sign;
        logic overflow;
    } srw_flags_s;

    // Condition flags left by the watchdog instruction
    localparam srw_flags_s WDT_FLAGS_VAL = '{zero: 1'b0, sign: 1'b0, overflow: 1'b0};

    typedef struct packed {
        logic       stop_en;
        logic       halt_en;
        logic [1:0] tap;
    } srw_wdmode_s;

    typedef enum logic { WD_IDLE, WD_RUN } srw_wd_e;

endpackage : srw_pkg

/* File: testbench/srw_far_model.sv */
/*
 * Far-side model: CPU state, watchdog instruction, wake pins, RC oscillator.
 * Assumes the bench calls its tasks; outputs change by NBA after CLK rises.
 */
`timescale 1ns/1ps
module srw_far_model #(
    parameter int RC_HALF = 3
) (
    // Clock
    input  wire logic  CLK,
    // CPU side
    output logic       CPU_STOP,
    output logic       CPU_HALT,
    output logic       WDT_EXEC,
    // Pins and oscillator
    output logic [7:0] PORT2_IN,
    output logic [7:0] PORT2_IS_OUT,
    output logic [3:1] PORT3_IN,
    output logic       RC_OSC
);
    int rc_cnt;
    initial begin
        {CPU_STOP, CPU_HALT, WDT_EXEC, RC_OSC} = 4'h0;
        {PORT2_IN, PORT2_IS_OUT, PORT3_IN} = 19'h0;
        rc_cnt = 0;
    end
    // Free running, derived from CLK: toggles once every RC_HALF rising edges of CLK
    always @(posedge CLK) begin
        rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
        if (rc_cnt == RC_HALF - 1) RC_OSC <= ~RC_OSC;
    end
    task exec_wdt;
        @(posedge CLK);
        WDT_EXEC <= 1'b1;
        @(posedge CLK);
        WDT_EXEC <= 1'b0;
    endtask : exec_wdt
    // Pins stay put until leave_stop, which the bench calls 6 cycles later
    task stop_with(input logic [7:0] p2, input logic [7:0] o, input logic [3:1] p3);
        @(posedge CLK);
        PORT2_IN     <= p2;
        PORT2_IS_OUT <= o;
        PORT3_IN     <= p3;
        CPU_STOP     <= 1'b1;
    endtask : stop_with
    task leave_stop;
        @(posedge CLK);
        CPU_STOP <= 1'b0;
        PORT2_IN <= ~PORT2_IN;
        PORT3_IN <= ~PORT3_IN;
    endtask : leave_stop
    task park(input logic halt, input int n);
        @(posedge CLK);
        CPU_HALT <= halt;
        CPU_STOP <= ~halt;
        repeat (n) @(posedge CLK);
        CPU_HALT <= 1'b0;
        CPU_STOP <= 1'b0;
    endtask : park
endmodule : srw_far_model

/* File: testbench/stop_recovery_and_watchdog_test.sv */
/*
 * Self-checking bench for srw_top with short watchdog taps 4..7.
 * Assumes srw_pkg and srw_far_model are compiled first.
 */
`timescale 1ns/1ps
module stop_recovery_and_watchdog_test;
    logic                clk;
    logic                rst;
    logic [7:0]          addr;
    logic [7:0]          wdata;
    logic                wr;
    logic                rd;
    logic [7:0]          rdata;
    logic                cpu_stop;
    logic                cpu_halt;
    logic                wdt_exec;
    logic                wake;
    logic                wake_dly;
    logic                wdt_reset;
    logic                flag_we;
    srw_pkg::srw_flags_s flags;
    logic                irq;
    logic [7:0]          p2;
    logic [7:0]          p2o;
    logic [3:1]          p3;
    logic                rc_osc;
    int                  n_fail;
    int                  checks_done;
    int                  n;
    int                  i;
    logic                warm;
    logic [7:0]          got;

    srw_top #(.TAP0(16'h0004), .TAP1(16'h0005), .TAP2(16'h0006),
        .TAP3(16'h0007), .DEF_TAP(2'h0)) DUT (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CPU_STOP(cpu_stop), .CPU_HALT(cpu_halt),
        .WDT_EXEC(wdt_exec), .WAKE(wake), .WAKE_DELAY_EN(wake_dly),
        .WDT_RESET(wdt_reset), .FLAG_WE(flag_we), .FLAGS(flags), .IRQ(irq),
        .PORT2_IN(p2), .PORT2_IS_OUT(p2o), .PORT3_IN(p3), .RC_OSC(rc_osc));
    srw_far_model far (.CLK(clk), .CPU_STOP(cpu_stop), .CPU_HALT(cpu_halt),
        .WDT_EXEC(wdt_exec), .PORT2_IN(p2), .PORT2_IS_OUT(p2o),
        .PORT3_IN(p3), .RC_OSC(rc_osc));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task conclude;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr
    task rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rdr
    task quiet(input int c, input string m);
        int s;
        s = 0;
        repeat (c) begin
            @(posedge clk);
            #1 if (wdt_reset !== 1'b0) s++;
        end
        chk(8'(s), 8'h0, m);
    endtask : quiet
    // Counts RC rises until the watchdog fires; a missing reset ends the run
    task wd_ticks(output int t);
        logic last;
        t = 0;
        last = rc_osc;
        for (int k = 0; k < 600 && wdt_reset !== 1'b1; k++) begin
            @(posedge clk);
            #1 if (rc_osc && !last) t++;
            last = rc_osc;
        end
        if (wdt_reset !== 1'b1) begin
            n_fail++;
            $display("[FAIL] t=%0t watchdog never fired", $time);
            conclude();
        end
    endtask : wd_ticks
    function automatic logic src_val(input logic [2:0] c, input logic [7:0] a,
        input logic [7:0] o, input logic [3:1] b);
        logic [7:0] e;
        e = a & ~o;
        case (c)
            3'h2: src_val = b[1];
            3'h3: src_val = b[2];
            3'h4: src_val = b[3];
            3'h5: src_val = e[7];
            3'h6: src_val = ~|e[3:0];
            default: src_val = ~|e;
        endcase
    endfunction : src_val
    task trial(input logic [2:0] c, input logic l, input logic d, input logic [7:0] a,
        input logic [7:0] o, input logic [3:1] b);
        logic e;
        int s;
        e = (c > 3'h1) && (src_val(c, a, o, b) == l);
        wrr(srw_pkg::ADDR_RECOVERY, {1'b0, l, d, c, 2'b00});
        far.stop_with(a, o, b);
        s = 0;
        repeat (6) begin
            @(posedge clk);
            #1 if (wake === 1'b1) s++;
        end
        chk(8'(s), 8'(e), "wake pulses");
        chk(8'(wake_dly), 8'(d), "delay enable");
        far.leave_stop();
        warm = warm | e;
        rdr(srw_pkg::ADDR_RECOVERY, got);
        chk(got, {warm, l, d, c, 2'b00}, "recovery read");
    endtask : trial

    initial begin
        {addr, wdata, wr, rd, rst, warm} = 20'h2;
        n_fail = 0;
        checks_done = 0;
        got = 8'($urandom(32'h7de4));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdr(srw_pkg::ADDR_RECOVERY, got);
        chk(got, 8'h20, "recovery reset");
        wrr(8'h3c, 8'h55);
        rdr(8'h3c, got);
        chk(got, 8'h00, "unmapped");
        wrr(srw_pkg::ADDR_WDMODE, 8'h03);
        rdr(srw_pkg::ADDR_WDMODE, got);
        chk(got, 8'h00, "mode hidden");
        $display("test registers done");
        quiet(60, "idle fired");
        far.exec_wdt();
        #1 chk(8'({flag_we, flags}), 8'({1'b1, srw_pkg::WDT_FLAGS_VAL}), "flags");
        repeat (3) begin
            quiet(24, "refresh fired");
            far.exec_wdt();
        end
        wd_ticks(n);
        chk(8'(n >= 7 && n <= 8), 8'h1, "tap3 period");
        rdr(srw_pkg::ADDR_IRQ_STAT, got);
        chk(got, 8'h02, "wdt status");
        wrr(srw_pkg::ADDR_WDMODE, 8'h00);
        far.exec_wdt();
        fork
            far.park(1'b1, 60);
            quiet(58, "halt fired");
        join
        fork
            far.park(1'b0, 60);
            quiet(58, "stop fired");
        join
        wd_ticks(n);
        chk(8'(n <= 4), 8'h1, "resume");
        repeat (125) @(posedge clk);
        wrr(srw_pkg::ADDR_WDMODE, 8'h03);
        far.exec_wdt();
        wd_ticks(n);
        chk(8'(n >= 4 && n <= 5), 8'h1, "locked");
        chk(8'(irq), 8'h0, "irq masked");
        wrr(srw_pkg::ADDR_IRQ_MASK, 8'h07);
        #1 chk(8'(irq), 8'h1, "irq set");
        rdr(srw_pkg::ADDR_IRQ_STAT, got);
        chk(got, 8'h06, "status");
        chk(8'(irq), 8'h0, "irq clear");
        $display("test watchdog done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        trial(3'h6, 1'b1, 1'b1, 8'h01, 8'h01, 3'h0);
        trial(3'h5, 1'b1, 1'b0, 8'h80, 8'h80, 3'h0);
        trial(3'h7, 1'b1, 1'b1, 8'hff, 8'hff, 3'h0);
        for (i = 0; i < 8; i++) begin
            trial(3'(i), 1'b1, 1'(i), 8'hff, 8'h00, 3'h7);
            trial(3'(i), 1'b0, 1'(i), 8'h00, 8'h00, 3'h0);
            trial(3'(i), 1'b1, 1'b1, 8'h00, 8'h00, 3'h0);
        end
        for (i = 0; i < 40; i++)
            trial(3'($urandom), 1'($urandom), 1'($urandom), 8'($urandom & $urandom),
                8'($urandom), 3'($urandom));
        $display("test recovery done");
        conclude();
    end
endmodule : stop_recovery_and_watchdog_test
